//--- verilog/dcwd_pkg.sv
// Functional notes
// - keep read-only 16-bit last fault code, zero after reset, cyclically readable.
// - keep 16-bit read-write command word, any value, reset zero, not retained.
// - fault reset fires only on a zero-to-one change of command bit 7.
// - command bit 11 enables the positive torque limit, clear disables it.
// - command bit 12 enables the negative torque limit, clear disables it.
// - bit 7 clear: bits 3..0 x110 shutdown, 0111 switch on, 1111 enable operation.
// - bit 7 clear: bit 1 low disables voltage; bit 1 high, bit 2 low quick stop.
// - profile position: bit 4 rise, bits 5,9 clear queues move until target reached.
// - profile position: bit 4 rise with bit 5 set starts next move at once.
// - profile position: bit 4 rise, bit 9 set, bit 5 clear continues then moves.
// - profile position: bit 6 clear absolute target, set relative to current target.
// - in every mode bit 8 set halts the axis, clear lets operation proceed.
// - homing: bit 4 set with halt clear runs homing; bits 5,6,9 reserved zero.
// - interpolated position: bit 4 enables interpolation while halt is clear.
package dcwd_pkg;

  // object indices of the two registers
  localparam logic [15:0] IDX_FAULT_CODE = 16'h603f;
  localparam logic [15:0] IDX_CMD_WORD = 16'h6040;
  localparam logic [15:0] RST_FAULT_CODE = 16'h0000;
  localparam logic [15:0] RST_CMD_WORD = 16'h0000;

  // command word bit positions
  localparam int B_SWITCH_ON = 0;
  localparam int B_EN_VOLTAGE = 1;
  localparam int B_QUICK_STOP_N = 2;
  localparam int B_EN_OPERATION = 3;
  localparam int B_START = 4;
  localparam int B_IMMEDIATE = 5;
  localparam int B_RELATIVE = 6;
  localparam int B_FAULT_RESET = 7;
  localparam int B_HALT = 8;
  localparam int B_CONTINUE = 9;
  localparam int B_POS_TLIM = 11;
  localparam int B_NEG_TLIM = 12;

  // bits that must be zero outside profile position mode, bit 4 excepted in homing and interpolated position
  localparam logic [15:0] MODE_RSVD_MASK = 16'h0270;

  typedef enum logic [2:0] {
    MODE_NONE = 3'b000,
    MODE_PROFILE_POS = 3'b001,
    MODE_PROFILE_VEL = 3'b010,
    MODE_PROFILE_TRQ = 3'b011,
    MODE_HOMING = 3'b100,
    MODE_INTERP_POS = 3'b101,
    MODE_CYCLIC = 3'b110
  } dcwd_mode_t;

  typedef enum logic [2:0] {
    SC_NONE = 3'b000,
    SC_SHUTDOWN = 3'b001,
    SC_SWITCH_ON = 3'b010,
    SC_ENABLE_OP = 3'b011,
    SC_DISABLE_VOLTAGE = 3'b100,
    SC_QUICK_STOP = 3'b101
  } dcwd_state_cmd_t;

  typedef enum logic [1:0] {
    MV_QUEUED = 2'b00,
    MV_IMMEDIATE = 2'b01,
    MV_CONTINUE = 2'b10
  } dcwd_move_kind_t;

  // level outputs that steer the drive
  typedef struct packed {
    dcwd_state_cmd_t state_cmd;
    logic halt;
    logic pos_tlim_en;
    logic neg_tlim_en;
    logic relative;
    logic homing_run;
    logic interp_en;
  } dcwd_drive_cmd_t;

endpackage

//--- verilog/dcwd_decoder.sv
`timescale 1ns/100ps
module dcwd_decoder (
  input wire logic clk_sys,
  input wire logic nrst,
  // service (acyclic) object access
  input wire logic obj_req,
  input wire logic obj_wr,
  input wire logic [15:0] obj_index,
  input wire logic [15:0] obj_wdata,
  output logic [15:0] obj_rdata,
  output logic obj_ack,
  output logic obj_err,
  // cyclic process data
  input wire logic pdo_valid,
  input wire logic [15:0] pdo_cmd_word,
  output logic [15:0] pdo_fault_code,
  // drive side
  input wire logic alarm_valid,
  input wire logic [15:0] alarm_code,
  input wire dcwd_pkg::dcwd_mode_t op_mode,
  input wire logic target_reached,
  output dcwd_pkg::dcwd_drive_cmd_t drive_cmd,
  output logic [15:0] cmd_word,
  output logic fault_reset,
  output logic move_start,
  output dcwd_pkg::dcwd_move_kind_t move_kind,
  output logic move_pending,
  output logic mode_rsvd_err
);

  // ==========================================================
  // reset release
  // ==========================================================
  logic [1:0] rst_sync;
  logic rst_n;

  // async assert, two-flop release so all logic leaves reset on one edge
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ==========================================================
  // command word acceptance
  // ==========================================================
  logic obj_cmd_wr;
  logic cmd_load;
  logic [15:0] next_cmd_word;
  logic rise_fault_reset;
  logic rise_start;
  logic is_pp;

  // cyclic data wins when both sources write in one cycle: it is the newer view
  assign obj_cmd_wr = obj_req && obj_wr && (obj_index == dcwd_pkg::IDX_CMD_WORD);
  assign cmd_load = pdo_valid || obj_cmd_wr;
  assign next_cmd_word = pdo_valid ? pdo_cmd_word : obj_wdata;

  // edges are taken against the last accepted word, not against time
  assign rise_fault_reset = cmd_load && next_cmd_word[dcwd_pkg::B_FAULT_RESET]
                            && !cmd_word[dcwd_pkg::B_FAULT_RESET];
  assign rise_start = cmd_load && next_cmd_word[dcwd_pkg::B_START]
                      && !cmd_word[dcwd_pkg::B_START];
  assign is_pp = (op_mode == dcwd_pkg::MODE_PROFILE_POS);

  // full 16-bit value stored, reserved bits kept but never decoded
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmd_word <= dcwd_pkg::RST_CMD_WORD;
    end else if (cmd_load) begin
      cmd_word <= next_cmd_word;
    end
  end

  // ==========================================================
  // fault code register
  // ==========================================================
  logic [15:0] fault_code;

  // a new alarm always lands, even in the cycle a fault reset is issued
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fault_code <= dcwd_pkg::RST_FAULT_CODE;
    end else if (alarm_valid) begin
      fault_code <= alarm_code;
    end
  end
  assign pdo_fault_code = fault_code;

  // ==========================================================
  // service object access
  // ==========================================================
  // one-cycle answer; writes to the read-only code and unknown indices fail
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      obj_ack <= 1'b0;
      obj_err <= 1'b0;
      obj_rdata <= 16'h0000;
    end else begin
      obj_ack <= obj_req;
      obj_err <= 1'b0;
      obj_rdata <= 16'h0000;
      if (obj_req) begin
        if (obj_index == dcwd_pkg::IDX_FAULT_CODE) begin
          obj_err <= obj_wr;
          obj_rdata <= obj_wr ? 16'h0000 : fault_code;
        end else if (obj_index == dcwd_pkg::IDX_CMD_WORD) begin
          obj_rdata <= obj_wr ? 16'h0000 : cmd_word;
        end else begin
          obj_err <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // state command decode
  // ==========================================================
  dcwd_pkg::dcwd_state_cmd_t next_state_cmd;

  // voltage removal outranks quick stop, which outranks the rest
  always_comb begin
    next_state_cmd = dcwd_pkg::SC_NONE;
    if (!cmd_word[dcwd_pkg::B_FAULT_RESET]) begin
      if (!cmd_word[dcwd_pkg::B_EN_VOLTAGE]) begin
        next_state_cmd = dcwd_pkg::SC_DISABLE_VOLTAGE;
      end else if (!cmd_word[dcwd_pkg::B_QUICK_STOP_N]) begin
        next_state_cmd = dcwd_pkg::SC_QUICK_STOP;
      end else if (!cmd_word[dcwd_pkg::B_SWITCH_ON]) begin
        next_state_cmd = dcwd_pkg::SC_SHUTDOWN;
      end else if (cmd_word[dcwd_pkg::B_EN_OPERATION]) begin
        next_state_cmd = dcwd_pkg::SC_ENABLE_OP;
      end else begin
        next_state_cmd = dcwd_pkg::SC_SWITCH_ON;
      end
    end
  end

  // ==========================================================
  // level outputs to the drive
  // ==========================================================
  // registered one cycle after the word so all fields change together
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      drive_cmd <= '0;
    end else begin
      drive_cmd.state_cmd <= next_state_cmd;
      drive_cmd.halt <= cmd_word[dcwd_pkg::B_HALT];
      drive_cmd.pos_tlim_en <= cmd_word[dcwd_pkg::B_POS_TLIM];
      drive_cmd.neg_tlim_en <= cmd_word[dcwd_pkg::B_NEG_TLIM];
      drive_cmd.relative <= is_pp && cmd_word[dcwd_pkg::B_RELATIVE];
      drive_cmd.homing_run <= (op_mode == dcwd_pkg::MODE_HOMING) && cmd_word[dcwd_pkg::B_START]
                              && !cmd_word[dcwd_pkg::B_HALT];
      drive_cmd.interp_en <= (op_mode == dcwd_pkg::MODE_INTERP_POS) && cmd_word[dcwd_pkg::B_START]
                             && !cmd_word[dcwd_pkg::B_HALT];
    end
  end

  // flag any mode-reserved bit the master left set; decode ignores them anyway
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_rsvd_err <= 1'b0;
    end else if (op_mode == dcwd_pkg::MODE_HOMING) begin
      mode_rsvd_err <= |(cmd_word & dcwd_pkg::MODE_RSVD_MASK & ~(16'h0001 << dcwd_pkg::B_START));
    end else if (is_pp || op_mode == dcwd_pkg::MODE_INTERP_POS) begin
      mode_rsvd_err <= is_pp ? 1'b0 : |(cmd_word & dcwd_pkg::MODE_RSVD_MASK & ~(16'h0001 << dcwd_pkg::B_START));
    end else begin
      mode_rsvd_err <= |(cmd_word & dcwd_pkg::MODE_RSVD_MASK);
    end
  end

  // ==========================================================
  // fault reset pulse
  // ==========================================================
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fault_reset <= 1'b0;
    end else begin
      fault_reset <= rise_fault_reset;
    end
  end

  // ==========================================================
  // profile position move start
  // ==========================================================
  logic pp_queue;
  logic pp_now;
  logic pending_fire;

  // bit 5 wins over bit 9, so immediate is checked first
  assign pp_queue = is_pp && rise_start && !next_cmd_word[dcwd_pkg::B_IMMEDIATE]
                    && !next_cmd_word[dcwd_pkg::B_CONTINUE];
  assign pp_now = is_pp && rise_start && !pp_queue;
  assign pending_fire = move_pending && target_reached && !pp_now;

  // a queued move waits for target reached; a new queue request in the fire
  // cycle re-arms instead of being lost
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      move_pending <= 1'b0;
    end else if (pp_queue) begin
      move_pending <= 1'b1;
    end else if (pp_now || pending_fire || !is_pp) begin
      move_pending <= 1'b0;
    end
  end

  // start pulse and its kind; the continue kind tells the profiler to keep
  // the present speed to the present target before chaining
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      move_start <= 1'b0;
      move_kind <= dcwd_pkg::MV_QUEUED;
    end else begin
      move_start <= pp_now || pending_fire;
      if (pp_now) begin
        move_kind <= next_cmd_word[dcwd_pkg::B_IMMEDIATE] ? dcwd_pkg::MV_IMMEDIATE
                     : dcwd_pkg::MV_CONTINUE;
      end else if (pending_fire) begin
        move_kind <= dcwd_pkg::MV_QUEUED;
      end
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_FAULT_CODE_LOAD: assert property (alarm_valid |=> pdo_fault_code == $past(alarm_code))
    else $error("fault code did not take alarm code");
  AST_FAULT_CODE_HOLD: assert property (!alarm_valid |=> $stable(pdo_fault_code))
    else $error("fault code changed without alarm");
  AST_CMD_LOAD: assert property (pdo_valid |=> cmd_word == $past(pdo_cmd_word))
    else $error("command word not loaded from cyclic data");
  AST_FAULT_RESET_EDGE: assert property (fault_reset |-> $past(cmd_word[7]) == 1'b0 && cmd_word[7])
    else $error("fault reset without rising bit 7");
  AST_FAULT_RESET_STEADY: assert property ($stable(cmd_word[7]) |-> !fault_reset)
    else $error("fault reset on steady word");
  AST_POS_TLIM: assert property (cmd_word[11] |=> drive_cmd.pos_tlim_en)
    else $error("positive torque limit not enabled");
  AST_NEG_TLIM: assert property (!cmd_word[12] |=> !drive_cmd.neg_tlim_en)
    else $error("negative torque limit not disabled");
  AST_ENABLE_OP: assert property (cmd_word[7:0] == 8'h0f |=> drive_cmd.state_cmd == dcwd_pkg::SC_ENABLE_OP)
    else $error("enable operation not decoded");
  AST_DISABLE_V: assert property (!cmd_word[7] && !cmd_word[1]
                                  |=> drive_cmd.state_cmd == dcwd_pkg::SC_DISABLE_VOLTAGE)
    else $error("disable voltage not decoded");
  AST_QUEUED_WAITS: assert property (move_pending && !target_reached && !pp_now |=> !move_start)
    else $error("queued move started before target reached");
  AST_IMMEDIATE: assert property (pp_now && next_cmd_word[5]
                                  |=> move_start && move_kind == dcwd_pkg::MV_IMMEDIATE)
    else $error("immediate move not started");
  AST_CONTINUE: assert property (pp_now && !next_cmd_word[5]
                                 |=> move_start && move_kind == dcwd_pkg::MV_CONTINUE)
    else $error("continue move not started");
  AST_HALT: assert property (cmd_word[8] |=> drive_cmd.halt && !drive_cmd.homing_run && !drive_cmd.interp_en)
    else $error("halt not applied");
  AST_INTERP: assert property (op_mode == dcwd_pkg::MODE_INTERP_POS && cmd_word[4] && !cmd_word[8]
                               |=> drive_cmd.interp_en)
    else $error("interpolation not enabled");
  // decode and access checks for the remaining cases
  AST_POS_TLIM_OFF: assert property (!cmd_word[11] |=> !drive_cmd.pos_tlim_en)
    else $error("positive torque limit not disabled");
  AST_NEG_TLIM_ON: assert property (cmd_word[12] |=> drive_cmd.neg_tlim_en)
    else $error("negative torque limit not enabled");
  AST_SHUTDOWN: assert property (!cmd_word[7] && cmd_word[2:0] == 3'b110
                                 |=> drive_cmd.state_cmd == dcwd_pkg::SC_SHUTDOWN)
    else $error("shutdown not decoded");
  AST_SWITCH_ON: assert property (!cmd_word[7] && cmd_word[3:0] == 4'b0111
                                  |=> drive_cmd.state_cmd == dcwd_pkg::SC_SWITCH_ON)
    else $error("switch on not decoded");
  AST_QUICK_STOP: assert property (!cmd_word[7] && cmd_word[2:1] == 2'b01
                                   |=> drive_cmd.state_cmd == dcwd_pkg::SC_QUICK_STOP)
    else $error("quick stop not decoded");
  AST_RESET_NO_CMD: assert property (cmd_word[7] |=> drive_cmd.state_cmd == dcwd_pkg::SC_NONE)
    else $error("state command decoded with bit 7 set");
  AST_CMD_SVC_LOAD: assert property (obj_req && obj_wr && obj_index == dcwd_pkg::IDX_CMD_WORD && !pdo_valid
                                     |=> cmd_word == $past(obj_wdata))
    else $error("command word not loaded from service write");
  AST_RO_REFUSED: assert property (obj_req && obj_wr && obj_index == dcwd_pkg::IDX_FAULT_CODE
                                   |=> obj_ack && obj_err)
    else $error("write to fault code not refused");
  AST_QUEUE_ARMS: assert property (pp_queue |=> move_pending)
    else $error("queued move not held pending");
  AST_QUEUED_FIRES: assert property (pending_fire |=> move_start && move_kind == dcwd_pkg::MV_QUEUED)
    else $error("queued move did not start at target reached");
  AST_RELATIVE: assert property (op_mode == dcwd_pkg::MODE_PROFILE_POS && cmd_word[6]
                                 |=> drive_cmd.relative)
    else $error("relative target not selected");
  AST_ABSOLUTE: assert property (!cmd_word[6] |=> !drive_cmd.relative)
    else $error("absolute target not selected");
  AST_HOMING: assert property (op_mode == dcwd_pkg::MODE_HOMING && cmd_word[4] && !cmd_word[8]
                               |=> drive_cmd.homing_run)
    else $error("homing not started");
  AST_NO_HOMING: assert property (!cmd_word[4] |=> !drive_cmd.homing_run)
    else $error("homing ran with start bit clear");
  AST_INTERP_OFF: assert property (!cmd_word[4] |=> !drive_cmd.interp_en)
    else $error("interpolation not disabled");
  AST_CYCLIC_RSVD: assert property (op_mode == dcwd_pkg::MODE_CYCLIC && cmd_word[4]
                                    |=> mode_rsvd_err)
    else $error("mode reserved bit not flagged");

  COV_FAULT_RESET: cover property (pdo_valid ##1 fault_reset);
  COV_QUEUED_MOVE: cover property (move_pending ##[1:20] move_start && move_kind == dcwd_pkg::MV_QUEUED);
  COV_ENABLE_OP: cover property (drive_cmd.state_cmd == dcwd_pkg::SC_ENABLE_OP);
  COV_OBJ_ERR: cover property (obj_ack && obj_err);
  COV_IMMEDIATE_MOVE: cover property (move_start && move_kind == dcwd_pkg::MV_IMMEDIATE);

endmodule

//--- test/dcwd_master.sv
`timescale 1ns/100ps
// =====
// fieldbus master model: cyclic words and service accesses
module dcwd_master (
  input wire logic clk_sys,
  input wire dcwd_pkg::dcwd_mode_t op_mode,
  output logic pdo_valid,
  output logic [15:0] pdo_cmd_word,
  output logic obj_req,
  output logic obj_wr,
  output logic [15:0] obj_index,
  output logic [15:0] obj_wdata
);
  // idle at time zero
  initial begin
    pdo_valid = 1'b0;
    pdo_cmd_word = 16'h0000;
    obj_req = 1'b0;
    obj_wr = 1'b0;
    obj_index = 16'h0000;
    obj_wdata = 16'h0000;
  end
  // one cyclic word; raw lets a scenario break the zero rules on purpose
  task automatic send(input logic [15:0] w, input bit raw);
    logic [15:0] m;
    m = 16'he400; // reserved bits written zero
    if (op_mode inside {dcwd_pkg::MODE_PROFILE_VEL, dcwd_pkg::MODE_PROFILE_TRQ, dcwd_pkg::MODE_CYCLIC}) begin
      m = 16'he670; // mode bits written zero
    end
    if (raw) begin
      m = 16'h0000;
    end
    @(negedge clk_sys);
    pdo_valid = 1'b1;
    pdo_cmd_word = w & ~m;
    @(negedge clk_sys);
    pdo_valid = 1'b0;
    pdo_cmd_word = ~pdo_cmd_word; // stale data must not look valid
  endtask
  // one service access; released lines show the inverse
  task automatic access(input logic wr, input logic [15:0] idx, input logic [15:0] d);
    @(negedge clk_sys);
    obj_req = 1'b1;
    obj_wr = wr;
    obj_index = idx;
    obj_wdata = d;
    @(negedge clk_sys);
    obj_req = 1'b0;
    obj_wr = ~wr;
    obj_index = ~idx;
    obj_wdata = ~d;
  endtask
endmodule

//--- test/tb_top.sv
`timescale 1ns/100ps
// =====
// bench for the command word decoder
module tb_top;
  logic clk_sys, nrst, alarm_valid, target_reached;
  logic pdo_valid, obj_req, obj_wr, obj_ack, obj_err, fault_reset, move_start, move_pending, mode_rsvd_err;
  logic [15:0] pdo_cmd_word, obj_index, obj_wdata, obj_rdata, pdo_fault_code, alarm_code, cmd_word, w;
  dcwd_pkg::dcwd_mode_t op_mode;
  dcwd_pkg::dcwd_drive_cmd_t drive_cmd;
  dcwd_pkg::dcwd_move_kind_t move_kind;
  dcwd_pkg::dcwd_move_kind_t q_mv[$];
  logic [17:0] q_obj[$];
  logic [17:0] e;
  int err_count, comparisons, cycles, exp_fr, fr_seen;
  logic [31:0] seed;
  dcwd_master dcwd_master_i (.clk_sys(clk_sys), .op_mode(op_mode), .pdo_valid(pdo_valid),
    .pdo_cmd_word(pdo_cmd_word), .obj_req(obj_req), .obj_wr(obj_wr), .obj_index(obj_index), .obj_wdata(obj_wdata));
  dcwd_decoder dcwd_decoder_i (.clk_sys(clk_sys), .nrst(nrst), .obj_req(obj_req), .obj_wr(obj_wr),
    .obj_index(obj_index), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_err(obj_err),
    .pdo_valid(pdo_valid), .pdo_cmd_word(pdo_cmd_word), .pdo_fault_code(pdo_fault_code),
    .alarm_valid(alarm_valid), .alarm_code(alarm_code), .op_mode(op_mode), .target_reached(target_reached),
    .drive_cmd(drive_cmd), .cmd_word(cmd_word), .fault_reset(fault_reset), .move_start(move_start),
    .move_kind(move_kind), .move_pending(move_pending), .mode_rsvd_err(mode_rsvd_err));
  // 200 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // state command expected from bits 3..0 with bit 7 clear
  function automatic dcwd_pkg::dcwd_state_cmd_t exp_sc(input logic [15:0] v);
    if (!v[1]) return dcwd_pkg::SC_DISABLE_VOLTAGE;
    if (!v[2]) return dcwd_pkg::SC_QUICK_STOP;
    if (!v[0]) return dcwd_pkg::SC_SHUTDOWN;
    return v[3] ? dcwd_pkg::SC_ENABLE_OP : dcwd_pkg::SC_SWITCH_ON;
  endfunction
  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
    comparisons++;
    if (g !== x) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, x, g);
    end
  endtask
  // send a word and let the registered levels settle
  task automatic put(input logic [15:0] v, input bit raw);
    dcwd_master_i.send(v, raw);
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic acc(input logic wr, input logic [15:0] idx, input logic [15:0] d, input logic er, input logic [15:0] x);
    q_obj.push_back({wr, er, x});
    dcwd_master_i.access(wr, idx, d);
    @(negedge clk_sys);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // answers are checked against the oldest note when they appear
  always @(negedge clk_sys) begin
    if (fault_reset === 1'b1) fr_seen++;
    if (obj_ack === 1'b1) begin
      e = (q_obj.size() > 0) ? q_obj.pop_front() : 18'h3ffff;
      chk("obj_err", {15'h0, e[16]}, {15'h0, obj_err});
      if (!e[17]) chk("obj_rdata", e[15:0], obj_rdata);
    end
    if (move_start === 1'b1) begin
      chk("move_kind", (q_mv.size() > 0) ? 16'(q_mv.pop_front()) : 16'hffff, 16'(move_kind));
    end
  end
  // hang guard, far above the expected run
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      $display("MISMATCH timeout exp %h got %h", 16'h0, 16'h1);
      results();
    end
  end
  // main sequence
  initial begin
    nrst = 1'b0;
    alarm_valid = 1'b0;
    alarm_code = 16'h0000;
    target_reached = 1'b0;
    op_mode = dcwd_pkg::MODE_NONE;
    seed = 32'h135b;
    repeat (3) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (4) @(negedge clk_sys);
    acc(0, 16'h603f, 16'h0, 0, 16'h0000);
    acc(0, 16'h6040, 16'h0, 0, 16'h0000);
    acc(0, 16'h6041, 16'h0, 1, 16'h0000);
    acc(1, 16'h603f, 16'h1234, 1, 16'h0);
    acc(1, 16'h6040, 16'hffff, 0, 16'h0);
    exp_fr++;
    acc(0, 16'h6040, 16'h0, 0, 16'hffff);
    $display("test registers done");
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      w = (seed[15:0] & 16'hfd00) | 16'(i);
      put(w, 1);
      chk("cmd_word", w, cmd_word);
      chk("state_cmd", 16'(exp_sc(w)), 16'(drive_cmd.state_cmd));
      chk("halt", {15'h0, w[8]}, {15'h0, drive_cmd.halt});
      chk("pos_tlim", {15'h0, w[11]}, {15'h0, drive_cmd.pos_tlim_en});
      chk("neg_tlim", {15'h0, w[12]}, {15'h0, drive_cmd.neg_tlim_en});
    end
    $display("test state commands done");
    put(16'h0080, 0);
    put(16'h0080, 0);
    exp_fr++;
    chk("state_cmd", 16'(dcwd_pkg::SC_NONE), 16'(drive_cmd.state_cmd));
    alarm_valid = 1'b1;
    alarm_code = 16'h0a91;
    @(negedge clk_sys);
    alarm_valid = 1'b0;
    alarm_code = 16'hf56e;
    @(negedge clk_sys);
    chk("fault_code", 16'h0a91, pdo_fault_code);
    acc(0, 16'h603f, 16'h0, 0, 16'h0a91);
    $display("test fault reset done");
    op_mode = dcwd_pkg::MODE_PROFILE_POS;
    put(16'h000f, 0);
    put(16'h001f, 0);
    chk("pending", 16'h1, {15'h0, move_pending});
    q_mv.push_back(dcwd_pkg::MV_QUEUED);
    target_reached = 1'b1;
    repeat (3) @(negedge clk_sys);
    target_reached = 1'b0;
    chk("pending", 16'h0, {15'h0, move_pending});
    put(16'h000f, 0);
    q_mv.push_back(dcwd_pkg::MV_IMMEDIATE);
    put(16'h023f, 0);
    put(16'h000f, 0);
    q_mv.push_back(dcwd_pkg::MV_CONTINUE);
    put(16'h021f, 0);
    put(16'h004f, 0);
    chk("relative", 16'h1, {15'h0, drive_cmd.relative});
    put(16'h000f, 0);
    chk("relative", 16'h0, {15'h0, drive_cmd.relative});
    chk("moves left", 16'h0, 16'(q_mv.size()));
    $display("test profile position done");
    op_mode = dcwd_pkg::MODE_HOMING;
    put(16'h001f, 0);
    chk("homing_run", 16'h1, {15'h0, drive_cmd.homing_run});
    put(16'h011f, 0);
    chk("homing_run", 16'h0, {15'h0, drive_cmd.homing_run});
    op_mode = dcwd_pkg::MODE_INTERP_POS;
    put(16'h001f, 0);
    chk("interp_en", 16'h1, {15'h0, drive_cmd.interp_en});
    put(16'h000f, 0);
    chk("interp_en", 16'h0, {15'h0, drive_cmd.interp_en});
    op_mode = dcwd_pkg::MODE_CYCLIC;
    put(16'h003f, 1);
    chk("rsvd_err", 16'h1, {15'h0, mode_rsvd_err});
    put(16'h003f, 0);
    chk("rsvd_err", 16'h0, {15'h0, mode_rsvd_err});
    op_mode = dcwd_pkg::MODE_PROFILE_VEL;
    put(16'h021f, 1);
    chk("rsvd_err", 16'h1, {15'h0, mode_rsvd_err});
    op_mode = dcwd_pkg::MODE_PROFILE_TRQ;
    put(16'h021f, 0);
    chk("rsvd_err", 16'h0, {15'h0, mode_rsvd_err});
    $display("test modes done");
    chk("fault_resets", 16'(exp_fr), 16'(fr_seen));
    chk("answers left", 16'h0, 16'(q_obj.size()));
    results();
  end
endmodule
